// File: hdl/bridge_pkg.sv
// Constants and field layout of the bridge driver control and status words
package bridge_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned NUM_DRV = 8;
  localparam int unsigned NUM_OUT = 5;
  localparam int unsigned NUM_HB = 3;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] COUNT_OVER = 5'h11;
  localparam logic [CNT_W-1:0] COUNT_FIRST = 5'h01;
  // Frame bit 0 selects the word pair
  localparam int unsigned SEL_BIT = 0;
  localparam logic SEL_WORD0 = 1'b0;
  // Control word 0
  localparam int unsigned CB_RESET = 15;
  localparam int unsigned CB_DIS_OL = 14;
  localparam int unsigned CB_DUTY = 13;
  localparam int unsigned CB_MON_HI = 11;
  localparam int unsigned CB_MON_LO = 9;
  localparam int unsigned CB_DRV_HI = 8;
  localparam int unsigned CB_DRV_LO = 1;
  // Control word 1: PWM enable and recovery enable per output
  localparam int unsigned CB_PWM_HI = 5;
  localparam int unsigned CB_PWM_LO = 1;
  localparam int unsigned CB_REC_HI = 10;
  localparam int unsigned CB_REC_LO = 6;
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;
  // Status words
  localparam logic ST_ALWAYS1 = 1'b1;
  localparam logic ST_UNUSED = 1'b0;
  localparam logic [1:0] ST_SUPPLY = 2'h0;
  // Monitor select codes
  localparam logic [2:0] MON_LAST = 3'h4;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned STARTUP_TIME_US = 100;
  localparam int unsigned STARTUP_CYCLES = STARTUP_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned REC_PERIOD_US = 50;
  localparam int unsigned REC_CYCLES = REC_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned DUTY_LOW_PCT = 12;
  localparam int unsigned DUTY_HIGH_PCT = 25;
  localparam int unsigned PCT_FULL = 100;
endpackage

// File: hdl/spi_link_if.sv
// Words passed between the serial link logic and the core logic
`timescale 1ns/100ps
interface spi_link_if;
  import bridge_pkg::*;
  logic [WORD_W-1:0] rxWord;
  logic [CNT_W-1:0] rxCount;
  logic [WORD_W-1:0] txWord0;
  logic [WORD_W-1:0] txWord1;
  logic noError;
  modport link (output rxWord, output rxCount, input txWord0, input txWord1, input noError);
  modport core (input rxWord, input rxCount, output txWord0, output txWord1, output noError);
endinterface

// File: hdl/spi_frame_link.sv
// Serial frame shifter running on the host's serial clock
`timescale 1ns/100ps
module spi_frame_link (
  input wire logic spiClk,          // Serial clock from host
  input wire logic spiCsN,          // Chip select, active low
  input wire logic spiDataIn,       // Serial data in
  output logic spiDataOut,          // Serial data out
  output logic spiDataOutEn,        // Data out drive enable
  spi_link_if.link link             // Words to and from the core
);
  import bridge_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0] count;
    logic [WORD_W-1:0] txWord;
  } rise_t;

  rise_t s;
  rise_t next_s;
  logic active;
  logic fellOnce;
  logic doBit;

  // Frame flags end with chip select since this clock stops between frames
  always_ff @(posedge spiClk or posedge spiCsN) begin
    if (spiCsN) begin
      active <= 1'b0;
    end else begin
      active <= 1'b1;
    end
  end

  always_comb begin
    next_s = s;
    if (!active) begin
      next_s.shift = {spiDataIn, s.shift[WORD_W-1:1]};
      next_s.count = COUNT_FIRST;
      // Bit 0 arrives on this edge and picks the status word
      next_s.txWord = (spiDataIn == SEL_WORD0) ? link.txWord0 : link.txWord1;
    end else begin
      next_s.shift = {spiDataIn, s.shift[WORD_W-1:1]};
      if (s.count != COUNT_OVER) begin
        next_s.count = s.count + COUNT_FIRST;
      end
    end
  end

  always_ff @(posedge spiClk) begin
    s <= next_s;
  end

  always_ff @(negedge spiClk or posedge spiCsN) begin
    if (spiCsN) begin
      fellOnce <= 1'b0;
      doBit <= 1'b0;
    end else begin
      fellOnce <= 1'b1;
      doBit <= (s.count < FRAME_BITS) ? s.txWord[s.count[CNT_W-2:0]] : 1'b0;
    end
  end

  // Before the first falling edge the line shows the no-error bit
  assign spiDataOut = fellOnce ? doBit : link.noError;
  assign spiDataOutEn = ~spiCsN;
  assign link.rxWord = s.shift;
  assign link.rxCount = s.count;
endmodule

// File: hdl/recovery_timer.sv
// Free-running on-window for over-current recovery pulsing
`timescale 1ns/100ps
module recovery_timer #(
  parameter int unsigned PERIOD = bridge_pkg::REC_CYCLES  // Cycles per recovery period
) (
  input wire logic ref_clk,         // Core clock
  input wire logic rst,             // Synchronous reset, active high
  input wire logic highDuty,        // Use the higher duty cycle
  output logic window               // Driver may retry while high
);
  import bridge_pkg::*;

  localparam int unsigned CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] ON_LOW = CW'(PERIOD * DUTY_LOW_PCT / PCT_FULL);
  localparam logic [CW-1:0] ON_HIGH = CW'(PERIOD * DUTY_HIGH_PCT / PCT_FULL);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic window;
  } rec_t;

  rec_t s;
  rec_t next_s;

  always_comb begin
    next_s = s;
    next_s.count = (s.count == LAST) ? '0 : s.count + ONE;
    next_s.window = s.count < (highDuty ? ON_HIGH : ON_LOW);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign window = s.window;
endmodule

// File: hdl/bridge_driver_control_status.sv
// Control and status words of the half-bridge and lamp driver
// Operation
// - Enable bits 1..8 switch drivers on
// - PWM enable gates driver with PWM input
// - Never both half-bridge drivers on
// - Bits 11..9 pick monitored high-side driver
// - Temperature warning reported, never disables outputs
// - Standby exit: not-ready, timer, outputs off
// - Over-current sets flag, disables driver
// - Recovery enable retries driver with duty pulsing
// - No recovery: off until host clears
// - No-error bit is NOR of flags
// - Disable-open-load drops open-load from no-error
// - Frame bit 0 selects word pair
// - Commit on chip-select rise, exactly 16 bits
// - Reset bit clears all status flags except not-ready
// - Duty 12% or 25%, low when warm
`timescale 1ns/100ps
module bridge_driver_control_status #(
  parameter int unsigned STARTUP_CYC = bridge_pkg::STARTUP_CYCLES, // Start-up delay
  parameter int unsigned REC_CYC = bridge_pkg::REC_CYCLES          // Recovery period
) (
  input wire logic ref_clk,                                  // Core clock, 200 MHz
  input wire logic rst,                                      // Synchronous reset
  input wire logic spiClk,                                   // Serial clock from host
  input wire logic spiCsN,                                   // Chip select, active low
  input wire logic spiDataIn,                                // Serial data in
  output logic spiDataOut,                                   // Serial data out
  output logic spiDataOutEn,                                 // Data out drive enable
  input wire logic activeMode,                               // High leaves standby
  input wire logic pwmIn,                                    // External PWM input
  input wire logic tempWarnIn,                               // Temperature warning
  input wire logic thermalShutdownIn,                        // Thermal shutdown event
  input wire logic [bridge_pkg::NUM_DRV-1:0] overCurrentIn,  // Over-current per driver
  input wire logic [bridge_pkg::NUM_DRV-1:0] openLoadIn,     // Open load per driver
  output logic [bridge_pkg::NUM_HB-1:0] lowSideDriver,       // Bridge low-side gates
  output logic [bridge_pkg::NUM_OUT-1:0] highSideDriver,     // High-side gates
  output logic [bridge_pkg::NUM_OUT-1:0] currentMonitorSel   // Monitor mux, one-hot, all zero for codes above 4
);
  import bridge_pkg::*;

  localparam int unsigned SW = 5 + 2 * NUM_DRV;
  localparam int unsigned I_CSN = SW - 1;
  localparam int unsigned I_ACT = SW - 2;
  localparam int unsigned I_PWM = SW - 3;
  localparam int unsigned I_TEMP = SW - 4;
  localparam int unsigned I_TSD = SW - 5;
  localparam int unsigned CW = $clog2(STARTUP_CYC + 1);
  localparam logic [CW-1:0] START_LAST = CW'(STARTUP_CYC - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  typedef struct packed {
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic csnD;
    logic activeD;
    logic [WORD_W-1:0] ctrl0;
    logic [WORD_W-1:0] ctrl1;
    logic notReady;
    logic [CW-1:0] startCount;
    logic [NUM_DRV-1:0] ocFlag;
    logic [NUM_DRV-1:0] olFlag;
    logic tempFlag;
    logic tsdFlag;
    logic noError;
    logic [WORD_W-1:0] snap0;
    logic [WORD_W-1:0] snap1;
    logic [NUM_DRV-1:0] drive;
    logic [NUM_OUT-1:0] monSel;
  } core_t;

  core_t s;
  core_t next_s;
  logic recWindow;
  logic highDuty;

  spi_link_if link();

  // Spread a per-output bit onto the drivers of that output
  function automatic logic [NUM_DRV-1:0] perDriver(input logic [NUM_OUT-1:0] perOut);
    logic [NUM_DRV-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_DRV; i++) begin
      if (i < 2 * NUM_HB) begin
        r[i] = perOut[i / 2];
      end else begin
        r[i] = perOut[i - NUM_HB];
      end
    end
    return r;
  endfunction

  function automatic logic [WORD_W-1:0] statusWord(input logic [NUM_DRV-1:0] flags,
      input logic thermal_shutdown_flag, input logic temp, input logic nrdy, input logic noErr);
    return {ST_ALWAYS1, ST_SUPPLY, thermal_shutdown_flag, temp, nrdy, ST_UNUSED, flags, noErr};
  endfunction

  spi_frame_link u_link (
    .spiClk(spiClk),
    .spiCsN(spiCsN),
    .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut),
    .spiDataOutEn(spiDataOutEn),
    .link(link.link)
  );

  recovery_timer #(
    .PERIOD(REC_CYC)
  ) u_recovery (
    .ref_clk(ref_clk),
    .rst(rst),
    .highDuty(highDuty),
    .window(recWindow)
  );

  // Warning forces the lower recovery duty
  assign highDuty = s.ctrl0[CB_DUTY] & ~s.sync2[I_TEMP];

  always_comb begin
    logic csnNow;
    logic csnRise;
    logic activeNow;
    logic commit;
    logic clearAll;
    logic [NUM_DRV-1:0] ocNow;
    logic [NUM_DRV-1:0] olNow;
    logic [NUM_DRV-1:0] req;
    logic [NUM_DRV-1:0] pwmEn;
    logic [NUM_DRV-1:0] recEn;
    logic [NUM_DRV-1:0] ocBlock;
    logic [NUM_DRV-1:0] olCount;
    logic [2:0] monCode;
    logic allowed;
    csnNow = 1'b1;
    csnRise = 1'b0;
    activeNow = 1'b0;
    commit = 1'b0;
    clearAll = 1'b0;
    ocNow = '0;
    olNow = '0;
    req = '0;
    pwmEn = '0;
    recEn = '0;
    ocBlock = '0;
    olCount = '0;
    monCode = '0;
    allowed = 1'b0;
    next_s = s;

    // Pins cross with two flops; only the second is read
    next_s.sync1 = {spiCsN, activeMode, pwmIn, tempWarnIn, thermalShutdownIn,
                    overCurrentIn, openLoadIn};
    next_s.sync2 = s.sync1;
    csnNow = s.sync2[I_CSN];
    activeNow = s.sync2[I_ACT];
    ocNow = s.sync2[2*NUM_DRV-1:NUM_DRV];
    olNow = s.sync2[NUM_DRV-1:0];
    next_s.csnD = csnNow;
    next_s.activeD = activeNow;
    csnRise = csnNow & ~s.csnD;

    // Link words are still while chip select is high and the clock idles
    commit = csnRise && (link.rxCount == FRAME_BITS);
    if (commit) begin
      if (link.rxWord[SEL_BIT] == SEL_WORD0) begin
        next_s.ctrl0 = link.rxWord;
        clearAll = link.rxWord[CB_RESET];
      end else begin
        next_s.ctrl1 = link.rxWord;
      end
    end

    // Start-up timer after leaving standby
    if (!activeNow) begin
      next_s.notReady = 1'b0;
      next_s.startCount = '0;
    end else if (!s.activeD) begin
      next_s.notReady = 1'b1;
      next_s.startCount = '0;
    end else if (s.notReady) begin
      if (s.startCount == START_LAST) begin
        next_s.notReady = 1'b0;
      end else begin
        next_s.startCount = s.startCount + ONE;
      end
    end

    // Sticky flags; a new event beats a clear in the same cycle
    next_s.ocFlag = (clearAll ? '0 : s.ocFlag) | ocNow;
    next_s.olFlag = (clearAll ? '0 : s.olFlag) | olNow;
    next_s.tempFlag = (clearAll ? 1'b0 : s.tempFlag) | s.sync2[I_TEMP];
    next_s.tsdFlag = (clearAll ? 1'b0 : s.tsdFlag) | s.sync2[I_TSD];

    olCount = s.ctrl0[CB_DIS_OL] ? '0 : s.olFlag;
    next_s.noError = ~(|{s.tsdFlag, s.tempFlag, s.notReady, s.ocFlag, olCount});

    // Host sees a frozen copy while a frame is in flight
    if (csnNow) begin
      next_s.snap0 = statusWord(s.ocFlag, s.tsdFlag, s.tempFlag, s.notReady, s.noError);
      next_s.snap1 = statusWord(s.olFlag, s.tsdFlag, s.tempFlag, s.notReady, s.noError);
    end

    // Driver gating
    req = s.ctrl0[CB_DRV_HI:CB_DRV_LO];
    pwmEn = perDriver(s.ctrl1[CB_PWM_HI:CB_PWM_LO]);
    recEn = perDriver(s.ctrl1[CB_REC_HI:CB_REC_LO]);
    req = req & ~(pwmEn & {NUM_DRV{~s.sync2[I_PWM]}});
    for (int k = 0; k < NUM_HB; k++) begin
      // Both requested means neither conducts, avoiding shoot-through
      if (req[2*k] && req[2*k+1]) begin
        req[2*k] = 1'b0;
        req[2*k+1] = 1'b0;
      end
    end
    ocBlock = s.ocFlag & ~(recEn & {NUM_DRV{recWindow}});
    // Temperature warning deliberately absent from this term
    // First active cycle waits until the not-ready flag has been set
    allowed = activeNow & s.activeD & ~s.notReady & ~s.tsdFlag;
    next_s.drive = req & ~ocBlock & {NUM_DRV{allowed}};

    monCode = s.ctrl0[CB_MON_HI:CB_MON_LO];
    next_s.monSel = '0;
    if (monCode <= MON_LAST) begin
      next_s.monSel[monCode] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.sync1[I_CSN] <= 1'b1;
      s.sync2[I_CSN] <= 1'b1;
      s.csnD <= 1'b1;
      s.ctrl0 <= CTRL_RESET;
      s.ctrl1 <= CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign link.txWord0 = s.snap0;
  assign link.txWord1 = s.snap1;
  assign link.noError = s.noError;

  always_comb begin
    for (int k = 0; k < NUM_HB; k++) begin
      lowSideDriver[k] = s.drive[2*k];
      highSideDriver[k] = s.drive[2*k+1];
    end
    for (int k = NUM_HB; k < NUM_OUT; k++) begin
      highSideDriver[k] = s.drive[k+NUM_HB];
    end
  end

  assign currentMonitorSel = s.monSel;
endmodule

// File: verification/bridge_checker_properties.sv
// Port-level assertions for the driver control and status block
`timescale 1ns/100ps
module bridge_checker_properties #(
  parameter int unsigned STARTUP_CYC = bridge_pkg::STARTUP_CYCLES, // Start-up delay
  parameter int unsigned REC_CYC = bridge_pkg::REC_CYCLES          // Recovery period
) (
  input wire logic ref_clk,                 // Core clock
  input wire logic rst,                     // Synchronous reset
  input wire logic spiCsN,                  // Chip select, active low
  input wire logic spiDataOutEn,            // Data out drive enable
  input wire logic activeMode,              // High leaves standby
  input wire logic tempWarnIn,              // Temperature warning
  input wire logic [2:0] lowSideDriver,     // Bridge low sides
  input wire logic [4:0] highSideDriver,    // High sides
  input wire logic [4:0] currentMonitorSel  // Monitor select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_off: assert property ($fell(rst) |-> {lowSideDriver, highSideDriver} == 8'h00)
    else $error("driver on right after reset");
  a_bridge_exclusive: assert property ((lowSideDriver & highSideDriver[2:0]) == 3'h0)
    else $error("both drivers of a bridge on");
  a_monitor_onehot: assert property ($onehot0(currentMonitorSel))
    else $error("monitor select not one-hot");
  a_standby_off: assert property (!activeMode [*4] |=> {lowSideDriver, highSideDriver} == 8'h00)
    else $error("driver on in standby");
  a_startup_hold: assert property (!activeMode [*4] ##1 activeMode |=>
    ({lowSideDriver, highSideDriver} == 8'h00) [*8])
    else $error("driver on during start-up");
  a_dout_enable: assert property (spiDataOutEn == !spiCsN)
    else $error("data out enable does not follow chip select");
  a_monitor_frame: assert property (!spiCsN [*6] |=> $stable(currentMonitorSel))
    else $error("monitor select changed inside a frame");
  a_warn_keeps_on: assert property (spiCsN [*8] ##0 $rose(tempWarnIn) |=>
    $stable(lowSideDriver) [*6])
    else $error("warning changed a driver");
endmodule

// File: verification/spi_host_model.sv
// Host serial master driving frames into the block
`timescale 1ns/100ps
module spi_host_model (
  output logic spiClk,    // Serial clock, still between frames
  output logic spiCsN,    // Chip select, active low
  output logic spiDataIn, // Data to the block
  input wire logic doWire // Resolved data out line
);
  localparam time HALF = 80ns;
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiDataIn = 1'b0;
  end
  // Data moves after the falling edge, so it is held over every rising edge
  task automatic xfer(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
    rx = 16'h0000;
    #1.7;
    spiDataIn = tx[0];
    spiCsN = 1'b0;
    #HALF;
    for (int i = 0; i < nBits; i++) begin
      spiClk = 1'b1;
      if (i < 16) rx[i] = doWire;
      #HALF;
      spiClk = 1'b0;
      spiDataIn = tx[(i + 1) % 16];
      #HALF;
    end
    spiCsN = 1'b1;
    // Released line shows no stale level
    spiDataIn = ~spiDataIn;
    #100;
  endtask
endmodule

// File: verification/bridge_driver_control_status_tb.sv
// Self-checking bench for the driver control and status block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin nMismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module bridge_driver_control_status_tb;
  import bridge_pkg::*;
  localparam int unsigned REC = 100;
  logic ref_clk, rst, spiClk, spiCsN, spiDataIn, spiDataOut, spiDataOutEn, doWire, doLast;
  logic activeMode, pwmIn, tempWarnIn, tsdIn;
  logic [NUM_DRV-1:0] ocIn, olIn;
  logic [NUM_HB-1:0] ls;
  logic [NUM_OUT-1:0] hs, mon;
  logic [15:0] rx;
  int nMismatch = 0;
  int nCompared = 0;
  bridge_driver_control_status #(.STARTUP_CYC(20), .REC_CYC(REC)) uut (
    .ref_clk(ref_clk), .rst(rst), .spiClk(spiClk), .spiCsN(spiCsN), .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn), .activeMode(activeMode),
    .pwmIn(pwmIn), .tempWarnIn(tempWarnIn), .thermalShutdownIn(tsdIn), .overCurrentIn(ocIn),
    .openLoadIn(olIn), .lowSideDriver(ls), .highSideDriver(hs), .currentMonitorSel(mon));
  spi_host_model host (.spiClk(spiClk), .spiCsN(spiCsN), .spiDataIn(spiDataIn),
    .doWire(doWire));
  always @(spiDataOut or spiDataOutEn) if (spiDataOutEn) doLast = spiDataOut;
  assign doWire = spiDataOutEn ? spiDataOut : ~doLast;
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic xf(input logic [15:0] w, input int n);
    @(negedge ref_clk);
    host.xfer(w, n, rx);
  endtask
  task automatic count_on(output int n);
    n = 0;
    repeat (REC) begin
      @(negedge ref_clk);
      n += int'(hs[3] === 1'b1);
    end
  endtask
  task automatic t_startup;
    xf(16'h0004, 16);
    `CHK("hs standby", 5'h00, hs)
    cyc(1);
    activeMode = 1'b1;
    cyc(8);
    `CHK("hs starting", 5'h00, hs)
    cyc(40);
    `CHK("hs ready", 5'h01, hs)
    xf(16'h0004, 16);
    `CHK("status idle", 16'h8001, rx)
  endtask
  task automatic t_drivers;
    logic [15:0] w;
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      w = 16'(i << 9) | 16'(2 << i);
      e = 8'(1 << i);
      xf(w, 16);
      `CHK("low sides", {e[4], e[2], e[0]}, ls)
      `CHK("high sides", {e[7:5], e[3], e[1]}, hs)
      `CHK("monitor", i < 5 ? 5'(1 << i) : 5'h00, mon)
    end
    xf(16'h01fe, 16);
    `CHK("bridge lows", 3'h0, ls)
    `CHK("bridge highs", 5'h18, hs)
  endtask
  task automatic t_badframe;
    xf(16'h0080, 16);
    xf(16'h0002, 15);
    `CHK("short frame", 5'h08, hs)
    // A wrong commit of either 16-bit slice would switch a bridge driver
    xf(16'h0008, 17);
    `CHK("long frame", 3'h0, ls)
    `CHK("long frame hs", 5'h08, hs)
  endtask
  task automatic pulse_oc;
    cyc(1);
    ocIn[6] = 1'b1;
    cyc(4);
    ocIn[6] = 1'b0;
    cyc(10);
  endtask
  task automatic t_overcurrent;
    pulse_oc();
    `CHK("oc off", 5'h00, hs)
    xf(16'h0080, 16);
    `CHK("oc status", 16'h8080, rx)
    `CHK("oc held off", 5'h00, hs)
    xf(16'h8080, 16);
    `CHK("oc cleared", 5'h08, hs)
    xf(16'h0080, 16);
    `CHK("status cleared", 16'h8001, rx)
  endtask
  task automatic t_recovery;
    int n;
    xf(16'h0201, 16);
    pulse_oc();
    cyc(REC);
    count_on(n);
    `CHK("duty low", REC * DUTY_LOW_PCT / PCT_FULL, n)
    xf(16'h2080, 16);
    cyc(REC);
    count_on(n);
    `CHK("duty high", REC * DUTY_HIGH_PCT / PCT_FULL, n)
    tempWarnIn = 1'b1;
    cyc(REC);
    count_on(n);
    `CHK("duty warm", REC * DUTY_LOW_PCT / PCT_FULL, n)
    xf(16'h0001, 16);
    xf(16'ha080, 16);
    `CHK("warn status", 16'h8880, rx)
    `CHK("warm driver on", 5'h08, hs)
  endtask
  task automatic t_pwm;
    cyc(1);
    tempWarnIn = 1'b0;
    xf(16'h0021, 16);
    xf(16'h8100, 16);
    `CHK("pwm low", 5'h00, hs)
    cyc(1);
    pwmIn = 1'b1;
    cyc(6);
    `CHK("pwm high", 5'h10, hs)
  endtask
  task automatic t_openload;
    cyc(1);
    olIn[0] = 1'b1;
    cyc(4);
    olIn[0] = 1'b0;
    xf(16'h0001, 16);
    `CHK("open load", 16'h8002, rx)
    xf(16'h4000, 16);
    xf(16'h4000, 16);
    `CHK("open load ignored", 16'h8001, rx)
    xf(16'h8000, 16);
    xf(16'h0001, 16);
    `CHK("word1 cleared", 16'h8001, rx)
  endtask
  task automatic t_thermal;
    cyc(1);
    tsdIn = 1'b1;
    cyc(4);
    tsdIn = 1'b0;
    xf(16'h0080, 16);
    `CHK("tsd status", 16'h9000, rx)
    xf(16'h8080, 16);
    xf(16'h0080, 16);
    `CHK("tsd cleared", 16'h8001, rx)
    `CHK("driver after tsd", 5'h08, hs)
  endtask
  task automatic report_and_stop;
    if (nMismatch == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #400us;
    nMismatch++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    activeMode = 1'b0;
    pwmIn = 1'b0;
    tempWarnIn = 1'b0;
    tsdIn = 1'b0;
    ocIn = 8'h00;
    olIn = 8'h00;
    doLast = 1'b0;
    cyc(16);
    rst = 1'b0;
    cyc(4);
    t_startup();
    t_drivers();
    t_badframe();
    t_overcurrent();
    t_recovery();
    t_pwm();
    t_openload();
    t_thermal();
    report_and_stop();
  end
endmodule
bind bridge_driver_control_status bridge_checker_properties #(
  .STARTUP_CYC(STARTUP_CYC), .REC_CYC(REC_CYC)) chk (.ref_clk(ref_clk), .rst(rst),
  .spiCsN(spiCsN), .spiDataOutEn(spiDataOutEn), .activeMode(activeMode),
  .tempWarnIn(tempWarnIn), .lowSideDriver(lowSideDriver),
  .highSideDriver(highSideDriver), .currentMonitorSel(currentMonitorSel));
